// File: include/ubsfi_pkg.sv
// Constants, carrier types and summary of behaviour for the serial port support block.
// What this block does
// - In SPI slave mode a falling slave select activates the slave, which shifts data.
// - A rising slave select makes the slave inactive; no data accepted until next fall.
// - MISO output is always driven, also while the slave is inactive.
// - In SPI master mode the slave-select pin is ignored.
// - Rate is (256 + mantissa) * 2^exponent / 2^28 * F, shared by UART and SPI.
// - Flush aborts the running operation, stops shifting and clears all data buffers.
// - Receive-done and transmit-done flags each raise a request only when enabled.
// - Receive and transmit DMA triggers pulse on the same done events.
// - The transmit buffer serves as DMA destination and the receive data register as source.
// - The port offers control/status, UART control, generic control, data and baud groups.
// - Busy status reads one while transmitting or receiving, zero when idle.
// - The role bit selects SPI master at zero and SPI slave at one.
package ubsfi_pkg;
   localparam int unsigned BAUD_MANT_W = 8;
   localparam int unsigned BAUD_EXP_W = 5;
   localparam int unsigned BAUD_INC_W = 40;
   localparam int unsigned BAUD_FRAC_W = 27;
   localparam logic [8:0] BAUD_MANT_BASE = 9'h100;
   localparam int unsigned DATA_W = 8;
   localparam logic [3:0] SPI_HALF_LAST = 4'hF;
   localparam logic [2:0] SPI_BIT_LAST = 3'h7;
   localparam logic [4:0] UART_HALF_LAST = 5'h13;
   localparam logic [4:0] UART_START_HALF = 5'h00;
   localparam logic [4:0] UART_STOP_HALF = 5'h12;
   localparam logic [9:0] UART_IDLE_LINE = 10'h3FF;
   localparam logic [7:0] SPI_FILL = 8'h00;

   typedef enum logic [1:0] {
      TX_IDLE = 2'h0,
      TX_UART = 2'h1,
      TX_SPIM = 2'h2
   } ubsfi_tx_state_t;

   typedef struct packed {
      logic modeUart;
      logic spiSlave;
      logic clockPhaseSel;
      logic rxEnable;
      logic rxDoneIrqEn;
      logic txDoneIrqEn;
      logic [BAUD_MANT_W-1:0] baudMantissa;
      logic [BAUD_EXP_W-1:0] baudExponent;
   } ubsfi_cfg_t;

   typedef struct packed {
      logic slaveSelectIn;
      logic sck;
      logic mosi;
      logic miso;
      logic rxd;
   } ubsfi_pins_in_t;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic txd;
   } ubsfi_pins_out_t;

   typedef struct packed {
      logic busy;
      logic rxDoneFlag;
      logic txDoneFlag;
      logic rxDoneIrq;
      logic txDoneIrq;
      logic rxDmaTrigger;
      logic txDmaTrigger;
   } ubsfi_status_t;
endpackage

// File: rtl/ubsfi_baud.sv
// Fractional baud tick generator running at twice the programmed rate.
`timescale 1ns/1ps
`default_nettype none
module ubsfi_baud
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic restart,
   input wire logic [ubsfi_pkg::BAUD_MANT_W-1:0] mantissa,
   input wire logic [ubsfi_pkg::BAUD_EXP_W-1:0] exponent,
   output logic tick
);
   typedef struct packed {
      logic [ubsfi_pkg::BAUD_FRAC_W-1:0] acc;
      logic tick;
   } ubsfi_baud_state_t;

   localparam logic [ubsfi_pkg::BAUD_INC_W:0] LIMIT = (ubsfi_pkg::BAUD_INC_W+1)'(1)
      << ubsfi_pkg::BAUD_FRAC_W;

   ubsfi_baud_state_t q;
   ubsfi_baud_state_t d;
   logic [ubsfi_pkg::BAUD_INC_W-1:0] inc;
   logic [ubsfi_pkg::BAUD_INC_W:0] sum;

   always_comb
   begin
      d = q;
      // The half-rate denominator 2^27 gives two ticks per bit.
      inc = ubsfi_pkg::BAUD_INC_W'({ubsfi_pkg::BAUD_MANT_BASE[8], mantissa}) << exponent;
      sum = (ubsfi_pkg::BAUD_INC_W+1)'(q.acc) + (ubsfi_pkg::BAUD_INC_W+1)'(inc);
      // One subtraction suffices because legal rates never reach F.
      d.tick = sum >= LIMIT;
      d.acc = d.tick ? ubsfi_pkg::BAUD_FRAC_W'(sum - LIMIT) : ubsfi_pkg::BAUD_FRAC_W'(sum);
      if (restart)
      begin
         d = '0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign tick = q.tick;
endmodule
`default_nettype wire

// File: rtl/ubsfi_buffer.sv
// Two-entry transmit buffer with valid and ready on both sides and a flush.
`timescale 1ns/1ps
`default_nettype none
module ubsfi_buffer
#(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 2
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic flush,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   localparam int unsigned PTR_W = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("Buffer depth must be a power of two of at least two.");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0] wrPtr;
      logic [PTR_W-1:0] rdPtr;
      logic [PTR_W:0] count;
      logic ready;
   } ubsfi_buf_state_t;

   ubsfi_buf_state_t q;
   ubsfi_buf_state_t d;
   logic push;
   logic pop;

   always_comb
   begin
      d = q;
      push = inValid && q.ready;
      pop = outReady && (q.count != '0);
      if (push)
      begin
         d.mem[q.wrPtr] = inData;
         d.wrPtr = q.wrPtr + 1'b1;
      end
      if (pop)
      begin
         d.rdPtr = q.rdPtr + 1'b1;
      end
      d.count = q.count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      // Clearing the pointers empties the buffer in one cycle.
      if (flush)
      begin
         d.wrPtr = '0;
         d.rdPtr = '0;
         d.count = '0;
      end
      d.ready = d.count != (PTR_W+1)'(DEPTH);
   end

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         q <= '0;
         q.ready <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign inReady = q.ready;
   assign outValid = q.count != '0;
   assign outData = q.mem[q.rdPtr];
endmodule
`default_nettype wire

// File: rtl/ubsfi_usart.sv
// Serial port core: UART, SPI master and slave, flush, done events and DMA triggers.
`timescale 1ns/1ps
`default_nettype none
module ubsfi_usart
#(
   parameter int unsigned TX_DEPTH = 2
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire ubsfi_pkg::ubsfi_cfg_t cfg,
   input wire logic flush,
   input wire logic rxDoneFlagClr,
   input wire logic txDoneFlagClr,
   input wire logic [ubsfi_pkg::DATA_W-1:0] txData,
   input wire logic txValid,
   output logic txReady,
   output logic [ubsfi_pkg::DATA_W-1:0] rxData,
   output logic rxValid,
   input wire logic rxRead,
   input wire ubsfi_pkg::ubsfi_pins_in_t pinsIn,
   output ubsfi_pkg::ubsfi_pins_out_t pinsOut,
   output ubsfi_pkg::ubsfi_status_t status
);
   localparam int unsigned W = ubsfi_pkg::DATA_W;

   if (TX_DEPTH < 2)
   begin : g_bad_depth
      $error("Transmit buffer needs at least two entries.");
   end

   typedef struct packed {
      ubsfi_pkg::ubsfi_pins_in_t sync1;
      ubsfi_pkg::ubsfi_pins_in_t sync2;
      ubsfi_pkg::ubsfi_pins_in_t sync3;
      ubsfi_pkg::ubsfi_pins_in_t filt;
      ubsfi_pkg::ubsfi_pins_in_t filtPrev;
      ubsfi_pkg::ubsfi_tx_state_t txSt;
      logic [4:0] txHalf;
      logic [9:0] txShift;
      logic [W-1:0] spiShift;
      logic [W-1:0] spiRx;
      logic [2:0] spiCnt;
      logic ssActive;
      logic rxOn;
      logic [4:0] rxHalf;
      logic [W-1:0] rxShift;
      logic [W-1:0] rxData;
      logic rxValid;
      ubsfi_pkg::ubsfi_status_t st;
      ubsfi_pkg::ubsfi_pins_out_t po;
   } ubsfi_core_state_t;

   ubsfi_core_state_t q;
   ubsfi_core_state_t d;
   logic bufValid;
   logic [W-1:0] bufData;
   logic pop;
   logic txTick;
   logic rxTick;
   logic txRestart;
   logic rxRestart;
   logic evRx;
   logic spiSlaveMode;
   logic spiMasterMode;
   logic ssFall;
   logic ssRise;
   logic sckRise;
   logic sckFall;
   logic sampleEdge;
   logic shiftEdge;
   logic leading;
   logic [W-1:0] rxNext;
   logic [W-1:0] loadByte;

   ubsfi_buffer #(
      .WIDTH(W),
      .DEPTH(TX_DEPTH)
   ) u_txbuf (
      .clock(clock),
      .resetn(resetn),
      .flush(flush),
      .inValid(txValid),
      .inData(txData),
      .inReady(txReady),
      .outValid(bufValid),
      .outData(bufData),
      .outReady(pop)
   );

   ubsfi_baud u_txbaud (
      .clock(clock),
      .resetn(resetn),
      .restart(txRestart),
      .mantissa(cfg.baudMantissa),
      .exponent(cfg.baudExponent),
      .tick(txTick)
   );

   ubsfi_baud u_rxbaud (
      .clock(clock),
      .resetn(resetn),
      .restart(rxRestart),
      .mantissa(cfg.baudMantissa),
      .exponent(cfg.baudExponent),
      .tick(rxTick)
   );

   always_comb
   begin
      d = q;
      pop = 1'b0;
      evRx = 1'b0;
      txRestart = 1'b0;
      rxRestart = 1'b0;
      rxNext = q.spiRx;
      loadByte = bufValid ? bufData : ubsfi_pkg::SPI_FILL;
      // A pin change counts once the second and third stages agree.
      d.sync1 = pinsIn;
      d.sync2 = q.sync1;
      d.sync3 = q.sync2;
      d.filt = ubsfi_pkg::ubsfi_pins_in_t'((q.sync2 & q.sync3) | (q.filt & (q.sync2 | q.sync3)));
      d.filtPrev = q.filt;
      ssFall = q.filtPrev.slaveSelectIn && !q.filt.slaveSelectIn;
      ssRise = !q.filtPrev.slaveSelectIn && q.filt.slaveSelectIn;
      // Edge detection on the sampled clock only works while it stays at or below F/8.
      sckRise = !q.filtPrev.sck && q.filt.sck;
      sckFall = q.filtPrev.sck && !q.filt.sck;
      spiSlaveMode = !cfg.modeUart && cfg.spiSlave;
      spiMasterMode = !cfg.modeUart && !cfg.spiSlave;
      sampleEdge = cfg.clockPhaseSel ? sckFall : sckRise;
      shiftEdge = cfg.clockPhaseSel ? sckRise : sckFall;
      leading = !q.txHalf[0];
      if (rxRead)
      begin
         d.rxValid = 1'b0;
      end
      // Slave select is only looked at in slave mode, never as master.
      if (spiSlaveMode)
      begin
         if (ssFall)
         begin
            d.ssActive = 1'b1;
            d.spiCnt = '0;
            if (!cfg.clockPhaseSel)
            begin
               d.spiShift = loadByte;
               pop = bufValid;
            end
         end
         else if (ssRise)
         begin
            // The bit count is kept here; the next fall clears it, so a mid-byte rise does not spoil the next byte.
            d.ssActive = 1'b0;
         end
         else if (q.ssActive)
         begin
            if (sampleEdge)
            begin
               rxNext = {q.spiRx[W-2:0], q.filt.mosi};
               d.spiRx = rxNext;
               d.spiCnt = q.spiCnt + 1'b1;
               if (q.spiCnt == ubsfi_pkg::SPI_BIT_LAST)
               begin
                  d.rxData = rxNext;
                  d.rxValid = 1'b1;
                  evRx = 1'b1;
               end
            end
            if (shiftEdge)
            begin
               if (q.spiCnt == '0)
               begin
                  d.spiShift = loadByte;
                  pop = bufValid;
               end
               else
               begin
                  d.spiShift = {q.spiShift[W-2:0], 1'b0};
               end
            end
         end
      end
      case (q.txSt)
         ubsfi_pkg::TX_IDLE:
         begin
            if (bufValid && cfg.modeUart)
            begin
               d.txShift = {1'b1, bufData, 1'b0};
               d.txHalf = '0;
               d.txSt = ubsfi_pkg::TX_UART;
               pop = 1'b1;
               txRestart = 1'b1;
            end
            else if (bufValid && spiMasterMode)
            begin
               d.spiShift = bufData;
               d.txHalf = '0;
               d.po.sck = 1'b0;
               d.txSt = ubsfi_pkg::TX_SPIM;
               pop = 1'b1;
               txRestart = 1'b1;
            end
         end
         ubsfi_pkg::TX_UART:
         begin
            if (txTick)
            begin
               d.txHalf = q.txHalf + 1'b1;
               if (q.txHalf[0])
               begin
                  d.txShift = {1'b1, q.txShift[9:1]};
               end
               if (q.txHalf == ubsfi_pkg::UART_HALF_LAST)
               begin
                  d.txSt = ubsfi_pkg::TX_IDLE;
               end
            end
         end
         ubsfi_pkg::TX_SPIM:
         begin
            if (txTick)
            begin
               d.po.sck = !q.po.sck;
               d.txHalf = q.txHalf + 1'b1;
               if (leading ^ cfg.clockPhaseSel)
               begin
                  rxNext = {q.spiRx[W-2:0], q.filt.miso};
                  d.spiRx = rxNext;
               end
               else if (!(cfg.clockPhaseSel && q.txHalf == '0))
               begin
                  d.spiShift = {q.spiShift[W-2:0], 1'b0};
               end
               if (q.txHalf[3:0] == ubsfi_pkg::SPI_HALF_LAST)
               begin
                  d.rxData = rxNext;
                  d.rxValid = 1'b1;
                  evRx = 1'b1;
                  d.txSt = ubsfi_pkg::TX_IDLE;
               end
            end
         end
         default:
         begin
            d.txSt = ubsfi_pkg::TX_IDLE;
         end
      endcase
      if (!q.rxOn)
      begin
         if (cfg.modeUart && cfg.rxEnable && q.filtPrev.rxd && !q.filt.rxd)
         begin
            d.rxOn = 1'b1;
            d.rxHalf = '0;
            rxRestart = 1'b1;
         end
      end
      else if (rxTick)
      begin
         d.rxHalf = q.rxHalf + 1'b1;
         if (!q.rxHalf[0])
         begin
            if (q.rxHalf == ubsfi_pkg::UART_START_HALF)
            begin
               d.rxOn = !q.filt.rxd;
            end
            else if (q.rxHalf == ubsfi_pkg::UART_STOP_HALF)
            begin
               d.rxOn = 1'b0;
               d.rxData = q.rxShift;
               d.rxValid = 1'b1;
               evRx = 1'b1;
            end
            else
            begin
               d.rxShift = {q.filt.rxd, q.rxShift[W-1:1]};
            end
         end
      end
      // Abort: the buffer empties through its own flush input.
      if (flush)
      begin
         pop = 1'b0;
         evRx = 1'b0;
         d.txSt = ubsfi_pkg::TX_IDLE;
         d.txShift = ubsfi_pkg::UART_IDLE_LINE;
         d.txHalf = '0;
         d.spiShift = '0;
         d.spiRx = '0;
         d.spiCnt = '0;
         d.ssActive = 1'b0;
         d.rxOn = 1'b0;
         d.rxHalf = '0;
         d.rxShift = '0;
         d.rxData = '0;
         d.rxValid = 1'b0;
         d.po.sck = 1'b0;
      end
      d.st.busy = (d.txSt != ubsfi_pkg::TX_IDLE) || d.rxOn || d.ssActive;
      // The set wins when an event meets a clear in the same cycle.
      d.st.rxDoneFlag = evRx || (q.st.rxDoneFlag && !rxDoneFlagClr);
      d.st.txDoneFlag = pop || (q.st.txDoneFlag && !txDoneFlagClr);
      d.st.rxDoneIrq = d.st.rxDoneFlag && cfg.rxDoneIrqEn;
      d.st.txDoneIrq = d.st.txDoneFlag && cfg.txDoneIrqEn;
      // Triggers pace DMA on the data paths in both clock phases.
      d.st.rxDmaTrigger = evRx;
      d.st.txDmaTrigger = pop;
      d.po.mosi = d.spiShift[W-1];
      d.po.miso = d.spiShift[W-1];
      d.po.txd = d.txShift[0];
   end

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         q <= '0;
         q.sync1 <= '1;
         q.sync2 <= '1;
         q.sync3 <= '1;
         q.filt <= '1;
         q.filtPrev <= '1;
         q.txShift <= ubsfi_pkg::UART_IDLE_LINE;
         q.po.txd <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // Data and status groups stand in for the five register views.
   assign rxData = q.rxData;
   assign rxValid = q.rxValid;
   assign pinsOut = q.po;
   assign status = q.st;
endmodule
`default_nettype wire

// File: sim/ubsfi_usart_props.sv
// Concurrent checks on the ports of the serial port core.
`timescale 1ns/1ps
`default_nettype none
module ubsfi_usart_props
(
   input wire logic clock,
   input wire logic resetn,
   input wire ubsfi_pkg::ubsfi_cfg_t cfg,
   input wire logic flush,
   input wire logic rxDoneFlagClr,
   input wire logic txDoneFlagClr,
   input wire logic txReady,
   input wire logic rxValid,
   input wire logic rxRead,
   input wire ubsfi_pkg::ubsfi_pins_out_t pinsOut,
   input wire ubsfi_pkg::ubsfi_status_t status
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   a_flush_idles_port:
      assert property (flush |=> !status.busy && !rxValid && txReady)
      else $error("flush left the port active");
   a_rx_irq_gate:
      assert property (1'b1 |=> status.rxDoneIrq == (status.rxDoneFlag && $past(cfg.rxDoneIrqEn)))
      else $error("rx request does not follow flag and enable");
   a_tx_irq_gate:
      assert property (1'b1 |=> status.txDoneIrq == (status.txDoneFlag && $past(cfg.txDoneIrqEn)))
      else $error("tx request does not follow flag and enable");
   a_rx_event_pair:
      assert property (status.rxDmaTrigger |-> status.rxDoneFlag && rxValid ##1 !status.rxDmaTrigger)
      else $error("rx trigger not paired with rx done");
   a_tx_event_pair:
      assert property (status.txDmaTrigger |-> status.txDoneFlag ##1 !status.txDmaTrigger)
      else $error("tx trigger not paired with tx done");
   a_rx_flag_holds:
      assert property (status.rxDoneFlag && !rxDoneFlagClr |=> status.rxDoneFlag)
      else $error("rx done flag lost");
   a_tx_flag_clear:
      assert property (txDoneFlagClr |=> !status.txDoneFlag || status.txDmaTrigger)
      else $error("tx done flag not cleared");
   a_rx_read_clears:
      assert property (rxRead |=> !rxValid || status.rxDmaTrigger)
      else $error("read did not clear rx valid");
   a_txd_idle_high:
      assert property (cfg.modeUart && !status.busy |-> pinsOut.txd)
      else $error("txd low while port idle");
   a_sck_idle_low:
      assert property (!cfg.modeUart && !cfg.spiSlave && !status.busy |-> !pinsOut.sck)
      else $error("sck not low while master idle");
   cover property (status.rxDmaTrigger && cfg.modeUart);
   cover property (status.rxDmaTrigger && cfg.spiSlave);
   cover property (flush && status.busy);
endmodule
bind ubsfi_usart ubsfi_usart_props ubsfi_usart_props_inst (.clock(clock), .resetn(resetn),
   .cfg(cfg), .flush(flush), .rxDoneFlagClr(rxDoneFlagClr), .txDoneFlagClr(txDoneFlagClr),
   .txReady(txReady), .rxValid(rxValid), .rxRead(rxRead), .pinsOut(pinsOut), .status(status));
`default_nettype wire

// File: sim/ubsfi_peer.sv
// Link peer: UART and SPI echo, plus an SPI master that the bench commands.
`timescale 1ns/1ps
`default_nettype none
module ubsfi_peer
(
   input wire logic clock,
   input wire ubsfi_pkg::ubsfi_pins_out_t pinsOut,
   output ubsfi_pkg::ubsfi_pins_in_t pinsIn
);
   logic ssel = 1'h1;
   logic sclk = 1'h0;
   logic sdo = 1'h0;
   // Echo keeps the receive path busy without a second data source.
   assign pinsIn = '{slaveSelectIn: ssel, sck: sclk, mosi: sdo, miso: pinsOut.mosi,
      rxd: pinsOut.txd};
   // Half period of 8 cycles keeps the clock at F/16, under the slave limit.
   task automatic xfer(input logic sel, input logic [7:0] dout, output logic [7:0] din);
      @(posedge clock) ssel <= !sel;
      for (int i = 7; i >= 0; i--)
      begin
         sdo <= dout[i];
         repeat (8) @(posedge clock);
         sclk <= 1'h1;
         din[i] = pinsOut.miso;
         repeat (8) @(posedge clock);
         sclk <= 1'h0;
      end
      repeat (8) @(posedge clock);
      // A released data line must not keep its last level.
      sdo <= !sdo;
      ssel <= 1'h1;
   endtask
endmodule
`default_nettype wire

// File: sim/ubsfi_usart_tb_top.sv
// Self-checking bench for the serial port core with a link peer.
`timescale 1ns/1ps
`default_nettype none
module ubsfi_usart_tb_top;
   logic clock = 1'h0;
   logic resetn = 1'h0;
   ubsfi_pkg::ubsfi_cfg_t cfg = '0;
   logic flush = 1'h0;
   logic rxDoneFlagClr = 1'h0;
   logic txDoneFlagClr = 1'h0;
   logic [7:0] txData = 8'h00;
   logic txValid = 1'h0;
   logic rxRead = 1'h0;
   logic txReady;
   logic [7:0] rxData;
   logic rxValid;
   ubsfi_pkg::ubsfi_pins_in_t pinsIn;
   ubsfi_pkg::ubsfi_pins_out_t pinsOut;
   ubsfi_pkg::ubsfi_status_t status;
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;
   int rxTrig = 0;
   int txTrig = 0;
   always #4 clock = !clock;
   ubsfi_usart ubsfi_usart_inst (.clock(clock), .resetn(resetn), .cfg(cfg), .flush(flush),
      .rxDoneFlagClr(rxDoneFlagClr), .txDoneFlagClr(txDoneFlagClr), .txData(txData),
      .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
      .rxRead(rxRead), .pinsIn(pinsIn), .pinsOut(pinsOut), .status(status));
   ubsfi_peer ubsfi_peer_inst (.clock(clock), .pinsOut(pinsOut), .pinsIn(pinsIn));
   task automatic test_done();
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cycles++;
      rxTrig += (resetn && status.rxDmaTrigger === 1'h1);
      txTrig += (resetn && status.txDmaTrigger === 1'h1);
      if (cycles == 20000)
      begin
         miscompares++;
         test_done();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic longint period(input logic [7:0] m, input logic [4:0] e);
      return 64'h10000000 / ((64'h100 + m) << e);
   endfunction
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i])
      begin
         txData <= b[i];
         txValid <= 1'h1;
         @(posedge clock);
         while (txReady !== 1'h1) @(posedge clock);
      end
      txValid <= 1'h0;
   endtask
   task automatic rxGet(output logic [7:0] d);
      @(posedge clock);
      while (rxValid !== 1'h1) @(posedge clock);
      d = rxData;
      rxRead <= 1'h1;
      @(posedge clock);
      rxRead <= 1'h0;
   endtask
   task automatic t_uart();
      // Fastest UART rate, then the 76800 settings for 26 MHz and 24 MHz.
      logic [7:0] mant[3] = '{8'h00, 8'h83, 8'hA3};
      logic [4:0] expo[3] = '{5'h10, 5'h0B, 5'h0B};
      logic [7:0] d;
      longint len;
      for (int k = 0; k < 3; k++)
      begin
         // Rate only changes while the port is idle.
         cfg.baudMantissa <= mant[k];
         cfg.baudExponent <= expo[k];
         send('{8'h55});
         while (pinsOut.txd !== 1'h0) @(posedge clock);
         len = 0;
         do begin @(posedge clock); len++; end while (pinsOut.txd === 1'h0);
         // The start bit also spans the restart cycle and the rounding of the second tick.
         chk(8'(len >= period(mant[k], expo[k]) + 1 && len <= period(mant[k], expo[k]) + 2), 8'h01);
         rxGet(d);
         chk(d, 8'h55);
         while (status.busy !== 1'h0) @(posedge clock);
      end
      chk(8'(rxTrig), 8'h03);
      chk(8'(txTrig), 8'h03);
      chk({status.rxDoneIrq, status.txDoneIrq}, 8'h00);
      cfg.rxDoneIrqEn <= 1'h1;
      cfg.txDoneIrqEn <= 1'h1;
      repeat (2) @(posedge clock);
      chk({status.rxDoneIrq, status.txDoneIrq}, 8'h03);
      rxDoneFlagClr <= 1'h1;
      txDoneFlagClr <= 1'h1;
      @(posedge clock);
      rxDoneFlagClr <= 1'h0;
      txDoneFlagClr <= 1'h0;
      repeat (2) @(posedge clock);
      chk({status.rxDoneFlag, status.txDoneFlag, status.rxDoneIrq, status.txDoneIrq}, 8'h00);
      cfg.baudMantissa <= 8'h00;
      cfg.baudExponent <= 5'h10;
   endtask
   task automatic t_fill();
      logic [7:0] d;
      send('{8'hA1, 8'h5E, 8'h3C});
      rxGet(d);
      chk(d, 8'hA1);
      rxGet(d);
      chk(d, 8'h5E);
      rxGet(d);
      chk(d, 8'h3C);
   endtask
   task automatic t_flush();
      send('{8'h0F, 8'hF0});
      while (pinsOut.txd !== 1'h0) @(posedge clock);
      repeat (40) @(posedge clock);
      flush <= 1'h1;
      @(posedge clock);
      flush <= 1'h0;
      @(posedge clock);
      chk({status.busy, rxValid, txReady, pinsOut.txd}, 8'h03);
      // The buffered second word must never reach the line.
      repeat (400) @(posedge clock);
      chk({status.busy, rxValid, pinsOut.txd}, 8'h01);
   endtask
   task automatic t_spi_slave();
      logic [7:0] d;
      cfg.modeUart <= 1'h0;
      cfg.spiSlave <= 1'h1;
      send('{8'hC3});
      ubsfi_peer_inst.xfer(1'h1, 8'h5A, d);
      chk(d, 8'hC3);
      repeat (8) @(posedge clock);
      chk(status.busy, 8'h00);
      chk(8'(pinsOut.miso === 1'bz), 8'h00);
      rxGet(d);
      chk(d, 8'h5A);
      ubsfi_peer_inst.xfer(1'h0, 8'h3C, d);
      repeat (8) @(posedge clock);
      chk(rxValid, 8'h00);
      flush <= 1'h1;
      @(posedge clock);
      flush <= 1'h0;
      repeat (2) @(posedge clock);
      chk({status.busy, rxValid, txReady}, 8'h01);
   endtask
   task automatic t_spi_master();
      logic [7:0] d;
      logic last;
      int rises;
      int gap;
      cfg.spiSlave <= 1'h0;
      repeat (2) @(posedge clock);
      ubsfi_peer_inst.ssel <= 1'h0;
      repeat (10) @(posedge clock);
      chk(status.busy, 8'h00);
      send('{8'h96});
      last = 1'h0;
      rises = 0;
      gap = 0;
      while (rxValid !== 1'h1)
      begin
         @(posedge clock);
         gap += (rises == 1);
         rises += (pinsOut.sck === 1'h1 && !last);
         last = pinsOut.sck;
      end
      chk(8'(rises), 8'h08);
      chk(8'(gap), 8'(period(8'h00, 5'h10)));
      rxGet(d);
      chk(d, 8'h96);
      // Phase one raises the same DMA triggers; the bench paces it in software here.
      cfg.clockPhaseSel <= 1'h1;
      send('{8'h3A});
      rxGet(d);
      chk(d, 8'h3A);
      cfg.clockPhaseSel <= 1'h0;
      ubsfi_peer_inst.ssel <= 1'h1;
   endtask
   initial
   begin
      cfg.rxEnable = 1'h1;
      cfg.modeUart = 1'h1;
      cfg.baudExponent = 5'h10;
      repeat (6) @(posedge clock);
      resetn <= 1'h1;
      @(posedge clock);
      chk({1'h0, status}, 8'h00);
      chk({txReady, pinsOut.txd}, 8'h03);
      t_uart();
      t_fill();
      t_flush();
      t_spi_slave();
      t_spi_master();
      test_done();
   end
endmodule
`default_nettype wire
